// *** design/sadc_port.sv ***
// converter control and serial result port
// assumes host pins are asynchronous to clk_sys_i; the sampled result comes from
// the analog core on the same clock as a level bus, read on the last load cycle, just before busy rises
`include "sadc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sadc_port #(
   parameter int RES_W = `SADC_RES_BITS
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_b_i,
   input  wire logic             chip_sel_b_i,
   input  wire logic             rd_conv_i,
   input  wire logic             clock_source_select_i,
   input  wire logic             output_format_select_i,
   input  wire logic             power_down_in_i,
   input  wire logic             passthrough_i,
   input  wire logic             serial_bit_clock_i,
   input  wire logic [RES_W-1:0] core_result_i,
   output logic                  serial_bit_clock_o,
   output logic                  serial_bit_clock_oe_o,
   output logic                  serial_data_o,
   output logic                  frame_pulse_o,
   output logic                  busy_b_o,
   output logic                  hold_o,
   output logic                  low_power_o
);
   localparam int CNT_W = 10;

   // two-flop synchronisers, stage 1 read only by stage 2
   logic [6:0] s1_q;
   logic [6:0] s2_q;
   logic [6:0] s3_q;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         s1_q <= 7'h03;
         s2_q <= 7'h03;
         s3_q <= 7'h03;
      end else begin
         s1_q <= {output_format_select_i, power_down_in_i, passthrough_i, serial_bit_clock_i,
                  clock_source_select_i, rd_conv_i, chip_sel_b_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   logic cs_b;
   logic rc;
   logic ext_sel;
   logic bclk_rise;
   logic tag_lvl;
   logic pd_lvl;
   logic fmt_sel;
   assign cs_b      = s2_q[0];
   assign rc        = s2_q[1];
   assign ext_sel   = s2_q[2];
   assign bclk_rise = s2_q[3] && !s3_q[3];
   assign tag_lvl   = s2_q[4];
   assign pd_lvl    = s2_q[5];
   assign fmt_sel   = s2_q[6];

   // the two pins are ORed, so a conversion is a fall of the OR; a frame is rc rising with cs_b low or cs_b falling with rc high
   logic ored_q;
   logic conv_edge;
   logic frame_edge;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ored_q <= 1'b1;
      end else begin
         ored_q <= cs_b | rc;
      end
   end
   assign conv_edge  = ored_q && !(cs_b | rc);
   assign frame_edge = ext_sel && !cs_b && rc && (s3_q[0] || !s3_q[1]);

   sadc_pkg::sadc_conv_t cv_q;
   logic [CNT_W-1:0]     cv_cnt_q;
   logic [RES_W-1:0]     result_q;
   logic                 start_ok;
   logic                 load_pulse;
   assign start_ok   = conv_edge && !pd_lvl && (cv_q == sadc_pkg::SADC_CV_IDLE);
   assign load_pulse = (cv_q == sadc_pkg::SADC_CV_LOAD) && (cv_cnt_q == '0);

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         cv_q     <= sadc_pkg::SADC_CV_IDLE;
         cv_cnt_q <= '0;
         busy_b_o <= 1'b1;
         hold_o   <= 1'b0;
      end else begin
         case (cv_q)
            sadc_pkg::SADC_CV_IDLE: begin
               if (start_ok) begin
                  cv_q     <= sadc_pkg::SADC_CV_CONV;
                  cv_cnt_q <= CNT_W'(`SADC_CONV_CYC - 1);
                  busy_b_o <= 1'b0;
                  hold_o   <= 1'b1;
               end
            end
            sadc_pkg::SADC_CV_CONV: begin
               if (cv_cnt_q == '0) begin
                  cv_q     <= sadc_pkg::SADC_CV_LOAD;
                  cv_cnt_q <= CNT_W'(`SADC_LOAD_CYC - 1);
                  hold_o   <= 1'b0;
               end else begin
                  cv_cnt_q <= cv_cnt_q - 1'b1;
               end
            end
            sadc_pkg::SADC_CV_LOAD: begin
               if (cv_cnt_q == '0) begin
                  cv_q     <= sadc_pkg::SADC_CV_IDLE;
                  busy_b_o <= 1'b1;
               end else begin
                  cv_cnt_q <= cv_cnt_q - 1'b1;
               end
            end
            default: begin
               cv_q     <= sadc_pkg::SADC_CV_IDLE;
               busy_b_o <= 1'b1;
               hold_o   <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         low_power_o <= 1'b0;
      end else begin
         low_power_o <= pd_lvl;
      end
   end

   // the finished word waits here so a transmission in progress never loses it
   logic             buf_valid;
   logic             buf_ready;
   logic [RES_W-1:0] buf_data;
   logic             take;
   sadc_skid #(.W(RES_W)) u_buf (
      .clk_sys_i   (clk_sys_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (load_pulse),
      .in_ready_o  (),
      .in_data_i   (core_result_i),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_ready),
      .out_data_o  (buf_data)
   );

   sadc_pkg::sadc_tx_t tx_q;
   logic               tx_idle;
   assign tx_idle   = (tx_q == sadc_pkg::SADC_TX_IDLE);
   assign buf_ready = tx_idle && !(conv_edge && !ext_sel) && !frame_edge;
   assign take      = buf_valid && buf_ready;

   // result register survives power down; it changes only when a new word arrives
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         result_q <= `SADC_RESULT_RST;
      end else if (take) begin
         result_q <= buf_data;
      end
   end

   logic [RES_W-1:0] shift_q;
   logic [CNT_W-1:0] tx_cnt_q;
   logic [3:0]       bits_q;
   logic [RES_W-1:0] fmt_word;
   assign fmt_word = fmt_sel ? result_q
                   : {~result_q[`SADC_MSB_POS], result_q[`SADC_MSB_POS-1:0]};

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         tx_q                  <= sadc_pkg::SADC_TX_IDLE;
         tx_cnt_q              <= '0;
         bits_q                <= 4'h0;
         shift_q               <= '0;
         serial_bit_clock_o    <= 1'b0;
         serial_bit_clock_oe_o <= 1'b0;
         serial_data_o         <= 1'b0;
         frame_pulse_o         <= 1'b0;
      end else begin
         serial_bit_clock_oe_o <= !ext_sel;
         frame_pulse_o         <= 1'b0;
         case (tx_q)
            sadc_pkg::SADC_TX_IDLE: begin
               serial_bit_clock_o <= 1'b0;
               if (!ext_sel && start_ok) begin
                  tx_q          <= sadc_pkg::SADC_TX_WAIT;
                  tx_cnt_q      <= CNT_W'(`SADC_FIRST_CYC - 1);
                  shift_q       <= fmt_word;
                  serial_data_o <= fmt_word[`SADC_MSB_POS];
                  bits_q        <= 4'h0;
               end else if (frame_edge) begin
                  frame_pulse_o <= 1'b1;
                  tx_q          <= sadc_pkg::SADC_TX_HIGH;
                  shift_q       <= fmt_word;
                  serial_data_o <= fmt_word[`SADC_MSB_POS];
                  bits_q        <= 4'h0;
               end
            end
            sadc_pkg::SADC_TX_WAIT: begin
               if (tx_cnt_q == '0) begin
                  tx_q               <= sadc_pkg::SADC_TX_HIGH;
                  tx_cnt_q           <= CNT_W'(`SADC_HALF_CYC - 1);
                  serial_bit_clock_o <= 1'b1;
               end else begin
                  tx_cnt_q <= tx_cnt_q - 1'b1;
               end
            end
            sadc_pkg::SADC_TX_HIGH: begin
               if (ext_sel) begin
                  // the tag shifts in behind the word, so the bit taken on rise 1 leaves on rise 12
                  if (!cs_b && rc) begin
                     if (bclk_rise) begin
                        shift_q       <= {shift_q[RES_W-2:0], tag_lvl};
                        serial_data_o <= shift_q[RES_W-2];
                     end
                  end else begin
                     tx_q <= sadc_pkg::SADC_TX_IDLE;
                  end
               end else if (tx_cnt_q == '0) begin
                  // data moves on the falling bit clock so it is settled at the host's rise
                  tx_q               <= sadc_pkg::SADC_TX_LOW;
                  tx_cnt_q           <= CNT_W'(`SADC_HALF_CYC - 1);
                  serial_bit_clock_o <= 1'b0;
                  if (bits_q == 4'(RES_W - 1)) begin
                     bits_q        <= 4'(RES_W);
                     serial_data_o <= tag_lvl;
                  end else begin
                     bits_q        <= bits_q + 4'h1;
                     shift_q       <= {shift_q[RES_W-2:0], 1'b0};
                     serial_data_o <= shift_q[RES_W-2];
                  end
               end else begin
                  tx_cnt_q <= tx_cnt_q - 1'b1;
               end
            end
            sadc_pkg::SADC_TX_LOW: begin
               if (tx_cnt_q != '0) begin
                  tx_cnt_q <= tx_cnt_q - 1'b1;
               end else if (bits_q == 4'(RES_W)) begin
                  tx_q <= sadc_pkg::SADC_TX_IDLE;
               end else begin
                  tx_q               <= sadc_pkg::SADC_TX_HIGH;
                  tx_cnt_q           <= CNT_W'(`SADC_HALF_CYC - 1);
                  serial_bit_clock_o <= 1'b1;
               end
            end
            default: begin
               tx_q <= sadc_pkg::SADC_TX_IDLE;
            end
         endcase
      end
   end
endmodule // sadc_port
`default_nettype wire

// *** design/sadc_cfg.svh ***
// timing and field constants for the converter serial port
// assumes a 50 MHz system clock; included by bare name
//
// Summary of operation
// - with chip select low, falling read/convert edge holds sample and starts conversion.
// - internal bit clock: that same edge starts sending the previous result.
// - external clock: rising strobe or falling select emits frame pulse, starts send.
// - chip select and read/convert are ORed; action needs both low or one state.
// - busy low from conversion start until result is loaded into shift register.
// - power down high refuses conversions and enters reduced power.
// - power down keeps the last result in the output shift register.
// - internal mode: first bit clock edge about 450 ns after strobe falls.
// - internal mode: exactly 12 bit clock pulses per result, pin low between.
// - external mode: shift result bits in step with host bit clock.
// - format select high gives straight binary, low two's complement.
// - external mode: after 12 bits, echo passthrough input delayed 12 clocks.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
`define SADC_CLK_MHZ       50
`define SADC_RES_BITS      12
`define SADC_MSB_POS       11
`define SADC_CONV_NS       5700
`define SADC_CONV_CYC      ((`SADC_CONV_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_LOAD_NS       220
`define SADC_LOAD_CYC      ((`SADC_LOAD_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_FIRST_NS      450
`define SADC_FIRST_CYC     ((`SADC_FIRST_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_BITCLK_NS     440
`define SADC_HALF_CYC      ((`SADC_BITCLK_NS * `SADC_CLK_MHZ) / 2000)
`define SADC_RESULT_RST    12'h000
`endif

// *** design/sadc_pkg.sv ***
// types for the converter serial port
// assumes sadc_cfg.svh for numeric constants
package sadc_pkg;
   typedef enum logic [1:0] {
      SADC_CV_IDLE = 2'b00,
      SADC_CV_CONV = 2'b01,
      SADC_CV_LOAD = 2'b10
   } sadc_conv_t;
   typedef enum logic [1:0] {
      SADC_TX_IDLE = 2'b00,
      SADC_TX_WAIT = 2'b01,
      SADC_TX_HIGH = 2'b10,
      SADC_TX_LOW  = 2'b11
   } sadc_tx_t;
endpackage

// *** design/sadc_skid.sv ***
// two-entry buffer with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module sadc_skid #(
   parameter int W = 12
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_b_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   logic [W-1:0] mem_q [2];
   logic         wp_q;
   logic         rp_q;
   logic [1:0]   cnt_q;
   logic         push;
   logic         pop;

   assign in_ready_o  = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o  = mem_q[rp_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_q[wp_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
      end
   end
endmodule // sadc_skid
`default_nettype wire

// *** dv/sadc_port_sva.sv ***
// concurrent checks on the converter serial port pins
// assumes one clock domain and static mode/power-down pins around conversions
`timescale 1ns/100ps
`default_nettype none
module sadc_port_sva #(
   parameter int RES_W = 12
) (
   input wire logic             clk_sys_i,
   input wire logic             rst_b_i,
   input wire logic             chip_sel_b_i,
   input wire logic             rd_conv_i,
   input wire logic             clock_source_select_i,
   input wire logic             output_format_select_i,
   input wire logic             power_down_in_i,
   input wire logic             passthrough_i,
   input wire logic             serial_bit_clock_i,
   input wire logic [RES_W-1:0] core_result_i,
   input wire logic             serial_bit_clock_o,
   input wire logic             serial_bit_clock_oe_o,
   input wire logic             serial_data_o,
   input wire logic             frame_pulse_o,
   input wire logic             busy_b_o,
   input wire logic             hold_o,
   input wire logic             low_power_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   // counts busy-low cycles so the full 296 can be checked without long repeats
   logic [9:0] low_q;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i || busy_b_o) low_q <= 10'h000;
      else low_q <= low_q + 10'h001;
   end
   property p_busy_len; $rose(busy_b_o) |-> low_q == 10'h128; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy low length wrong");
   property p_hold; $fell(busy_b_o) |-> hold_o; endproperty
   a_hold: assert property (p_hold) else $error("hold missing at start");
   property p_start; $fell(busy_b_o) |-> !$past(chip_sel_b_i, 3) && !$past(rd_conv_i, 3); endproperty
   a_start: assert property (p_start) else $error("start without both pins low");
   property p_pd; power_down_in_i [*2] ##1 (power_down_in_i && busy_b_o) |=> busy_b_o; endproperty
   a_pd: assert property (p_pd) else $error("conversion in power down");
   property p_lp; power_down_in_i [*4] |-> low_power_o; endproperty
   a_lp: assert property (p_lp) else $error("low power not entered");
   property p_first;
      $fell(busy_b_o) && !clock_source_select_i |-> !serial_bit_clock_o [*8] ##15 $rose(serial_bit_clock_o);
   endproperty
   a_first: assert property (p_first) else $error("first bit clock late or early");
   property p_high; $rose(serial_bit_clock_o) |-> ##10 serial_bit_clock_o ##1 !serial_bit_clock_o; endproperty
   a_high: assert property (p_high) else $error("bit clock high time wrong");
   property p_idle; $rose(busy_b_o) |-> !serial_bit_clock_o; endproperty
   a_idle: assert property (p_idle) else $error("bit clock not idle low");
   property p_frame; frame_pulse_o |=> !frame_pulse_o; endproperty
   a_frame: assert property (p_frame) else $error("frame pulse too long");
   property p_fmode; frame_pulse_o |-> clock_source_select_i; endproperty
   a_fmode: assert property (p_fmode) else $error("frame in internal mode");
   c_int: cover property ($fell(busy_b_o) && !clock_source_select_i);
   c_frm: cover property (frame_pulse_o);
   c_pd: cover property (low_power_o);
endmodule // sadc_port_sva
bind sadc_port sadc_port_sva #(.RES_W(RES_W)) sadc_port_sva_inst (.*);
`default_nettype wire

// *** dv/sadc_host_model.sv ***
// host side: reads words on the device bit clock or on its own bit clock
// assumes the bench resolves the two-way bit clock into bclk_w_i
`timescale 1ns/100ps
`default_nettype none
module sadc_host_model (
   input wire logic bclk_w_i,
   input wire logic bclk_oe_i,
   input wire logic data_i,
   output var logic bclk_o
);
   logic [11:0] int_word;
   logic [31:0] ext_word;
   int          int_cnt = 0;
   initial bclk_o = 1'b0;
   always @(posedge bclk_w_i) begin
      if (bclk_oe_i) begin
         int_word <= {int_word[10:0], data_i};
         int_cnt  <= int_cnt + 1;
      end
   end
   // own clock rests low outside frames; sample just before each rise
   task automatic read_ext(input int n);
      ext_word = 32'h0000_0000;
      #7;
      repeat (n) begin
         #80 ext_word = {ext_word[30:0], data_i};
         bclk_o = 1'b1;
         #80 bclk_o = 1'b0;
      end
   endtask
endmodule // sadc_host_model
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the converter serial port
// assumes sadc_port, sadc_host_model and the bound checker are compiled
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
   logic        clk_sys_i, rst_b_i, cs_b, rd, css, fmt, pd, tag, hbclk;
   logic [11:0] core;
   logic        bclk_o, bclk_oe, sdata, frame, busy_b, hold, lowp;
   wire logic   bclk_w = bclk_oe ? bclk_o : hbclk;
   int          n_fail = 0;
   int          comparisons = 0;
   sadc_port sadc_port_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .chip_sel_b_i(cs_b),
      .rd_conv_i(rd), .clock_source_select_i(css), .output_format_select_i(fmt),
      .power_down_in_i(pd), .passthrough_i(tag), .serial_bit_clock_i(bclk_w),
      .core_result_i(core), .serial_bit_clock_o(bclk_o), .serial_bit_clock_oe_o(bclk_oe),
      .serial_data_o(sdata), .frame_pulse_o(frame), .busy_b_o(busy_b), .hold_o(hold),
      .low_power_o(lowp));
   sadc_host_model sadc_host_model_inst (.bclk_w_i(bclk_w), .bclk_oe_i(bclk_oe),
      .data_i(sdata), .bclk_o(hbclk));
   task automatic finish_test;
      $display("fails %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wait_sig(input bit f, input logic v);
      for (int i = 0; i < 400 && (f ? frame : busy_b) !== v; i++) begin
         @(posedge clk_sys_i);
         #1;
      end
      if ((f ? frame : busy_b) !== v) begin
         n_fail++;
         finish_test();
      end
   endtask
   task automatic drive(input logic c, input logic r);
      @(posedge clk_sys_i);
      cs_b <= c;
      rd   <= r;
   endtask
   // strobe low 280 ns, high again long before busy rises, starts over 10 us apart
   task automatic convert(input logic [11:0] res);
      sadc_host_model_inst.int_cnt = 0;
      drive(1'b0, 1'b0);
      core <= res;
      wait_sig(1'b0, 1'b0);
      repeat (10) @(posedge clk_sys_i);
      drive(1'b0, 1'b1);
      wait_sig(1'b0, 1'b1);
      repeat (220) @(posedge clk_sys_i);
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      rst_b_i = 1'b0;
      cs_b = 1'b1;
      rd = 1'b1;
      css = 1'b0;
      fmt = 1'b1;
      pd = 1'b0;
      tag = 1'b0;
      core = 12'h000;
      repeat (4) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      convert(12'h5A3);
      `CHK(sadc_host_model_inst.int_word, 12'h000)
      `CHK(sadc_host_model_inst.int_cnt, 12)
      convert(12'hC3C);
      `CHK(sadc_host_model_inst.int_word, 12'h5A3)
      `CHK(sadc_host_model_inst.int_cnt, 12)
      fmt <= 1'b0;
      convert(12'h111);
      `CHK(sadc_host_model_inst.int_word, 12'h43C)
      `CHK(bclk_oe, 1'b1)
      fmt <= 1'b1;
      pd <= 1'b1;
      css <= 1'b1;
      tag <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      drive(1'b0, 1'b0);
      repeat (20) @(posedge clk_sys_i);
      #1;
      `CHK(busy_b, 1'b1)
      `CHK(lowp, 1'b1)
      `CHK(bclk_oe, 1'b0)
      drive(1'b0, 1'b1);
      wait_sig(1'b1, 1'b1);
      sadc_host_model_inst.read_ext(24);
      `CHK(sadc_host_model_inst.ext_word[23:0], 24'h111FFF)
      drive(1'b1, 1'b1);
      pd <= 1'b0;
      drive(1'b1, 1'b0);
      repeat (5) @(posedge clk_sys_i);
      drive(1'b0, 1'b0);
      core <= 12'h7E8;
      wait_sig(1'b0, 1'b0);
      `CHK(hold, 1'b1)
      repeat (10) @(posedge clk_sys_i);
      drive(1'b0, 1'b1);
      wait_sig(1'b1, 1'b1);
      sadc_host_model_inst.read_ext(12);
      `CHK(sadc_host_model_inst.ext_word[11:0], 12'h111)
      wait_sig(1'b0, 1'b1);
      drive(1'b1, 1'b1);
      repeat (220) @(posedge clk_sys_i);
      drive(1'b0, 1'b1);
      wait_sig(1'b1, 1'b1);
      sadc_host_model_inst.read_ext(12);
      `CHK(sadc_host_model_inst.ext_word[11:0], 12'h7E8)
      drive(1'b1, 1'b1);
      finish_test();
   end
endmodule // tb
`default_nettype wire
